// ==== startup_seq_pkg.sv ====
// Constants, types and decoders shared by the start-up and soft-start sequencer.
package startup_seq_pkg;
   // Clock rate in kHz, so one millisecond is this many cycles.
   localparam int CLK_KHZ = 100000;
   // Memory check time in ms, and the least pre-ramp delay in ms.
   localparam int NVM_CHECK_MS = 5;
   localparam int MIN_DELAY_MS = 2;
   localparam int MS_CYC_DFLT = 1 * CLK_KHZ;
   localparam int NVM_CYC_DFLT = NVM_CHECK_MS * CLK_KHZ;
   // Reference resolution and full-scale code.
   localparam int VREF_STEPS = 1024;
   localparam logic [9:0] VREF_FULL = 10'h3ff;
   // Register byte offsets.
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_DELAY = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_CONFIG = 4'hc;
   // Control bit positions and reset values.
   localparam int CTRL_RESTORE = 0;
   localparam int CTRL_PRECISE = 1;
   localparam int CTRL_CMD_DLY = 2;
   localparam logic [7:0] DELAY_RST = 8'h00;
   // Series resistor assumed by each trim mode, in units of 10 ohm.
   localparam logic [9:0] SERIES_FIRST = 10'h3e8;
   localparam logic [9:0] SERIES_SECOND = 10'h362;
   // Strap level code and trim mode codes; custom means a measured resistor.
   localparam logic [1:0] LVL_CUSTOM = 2'h3;
   localparam logic [1:0] MODE_STD = 2'h0;
   localparam logic [1:0] MODE_FIRST = 2'h1;
   localparam logic [1:0] MODE_SECOND = 2'h2;
   // Delay in ms by coarse*3+fine, and ramp time in ms by level.
   localparam logic [7:0] DLY_TABLE [9] = '{8'h00, 8'h01, 8'h02, 8'h05, 8'h0a,
      8'h14, 8'h32, 8'h64, 8'hc8};
   localparam logic [7:0] RAMP_TABLE [3] = '{8'h00, 8'h05, 8'h0a};
   // Sequencer states.
   typedef enum logic [2:0] {
      ST_NVM = 3'b000,
      ST_PINS = 3'b001,
      ST_READY = 3'b010,
      ST_DELAY = 3'b011,
      ST_RAMP = 3'b100,
      ST_ON = 3'b101
   } state_t;
   // Strap pins as they arrive at the device.
   typedef struct packed {
      logic trim_second;
      logic [1:0] ramp_strap;
      logic [1:0] delay_coarse_strap;
      logic [1:0] delay_fine_strap;
      logic [1:0] vout_coarse_strap;
      logic [1:0] vout_fine_strap;
   } strap_t;
   // Avalon-MM request from the master.
   typedef struct packed {
      logic [3:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } avs_req_t;
   // Nine-way index of a pair of three-level straps.
   function automatic logic [3:0] idx9(input logic [1:0] c, input logic [1:0] f);
      idx9 = 4'({c, 1'b0} + c + f);
   endfunction
endpackage

// ==== startup_softstart_sequencer.sv ====
// Start-up and soft-start sequencer with an Avalon-MM register slave.
`timescale 1ns/1ps
`default_nettype none
module startup_softstart_sequencer #(
   parameter int MS_CYC = startup_seq_pkg::MS_CYC_DFLT,
   parameter int NVM_CYC = startup_seq_pkg::NVM_CYC_DFLT
) (
   // Clock and reset.
   input wire logic I_CLK,
   input wire logic I_RSTN,
   // Pins from the board, asynchronous.
   input wire logic I_ENABLE,
   input wire startup_seq_pkg::strap_t I_STRAPS,
   input wire logic [7:0] I_DLY_RES_MS,
   input wire logic [7:0] I_SS_RES_MS,
   // Stored settings from internal memory, same clock.
   input wire logic I_NVM_HAS_DLY,
   input wire logic [7:0] I_NVM_DLY_MS,
   // Register bus.
   input wire startup_seq_pkg::avs_req_t I_AVS,
   output logic [31:0] O_AVS_READDATA,
   output logic O_AVS_WAITREQUEST,
   // Sequencer outputs.
   output logic O_READY,
   output logic O_RAMPING,
   output logic O_POWER_ON,
   output logic [9:0] O_VREF,
   output logic [1:0] O_TRIM_MODE,
   output logic [3:0] O_VOUT_SEL,
   output logic [9:0] O_SERIES_R
);
   import startup_seq_pkg::*;

   state_t state_r; // Sequencer state.
   logic en_m_r, en_s_r; // Enable synchroniser.
   strap_t st_m_r, st_s_r; // Strap synchroniser.
   logic [7:0] dr_m_r, dr_s_r, sr_m_r, sr_s_r; // Measured resistor values.
   logic [19:0] tmr_r; // Memory check timer.
   logic [16:0] pre_r; // Millisecond prescaler.
   logic tick_r; // One-cycle millisecond tick.
   logic [8:0] dms_r; // Delay milliseconds counted.
   logic [15:0] stp_r; // Ramp step counter.
   logic [7:0] dly_cfg_r, ramp_ms_r, cmd_dly_r; // Loaded delay and ramp time, and commanded delay.
   logic [15:0] ramp_div_r; // Cycles per reference step.
   logic precise_r, cmd_en_r; // Control options.
   logic busy; // Initialisation in progress.
   logic take; // Bus request completes this edge.
   logic restore; // Restore command taken.
   logic [7:0] dly_eff; // Delay after the 2 ms floor.
   logic [8:0] goal; // Ticks to wait in the delay state.
   logic [7:0] ss_ms; // Ramp time from straps.

   // The first stage of each synchroniser feeds only the second stage.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         en_m_r <= 1'b0;
         en_s_r <= 1'b0;
         st_m_r <= '0;
         st_s_r <= '0;
         dr_m_r <= 8'h00;
         dr_s_r <= 8'h00;
         sr_m_r <= 8'h00;
         sr_s_r <= 8'h00;
      end
      else
      begin
         en_m_r <= I_ENABLE;
         en_s_r <= en_m_r;
         st_m_r <= I_STRAPS;
         st_s_r <= st_m_r;
         dr_m_r <= I_DLY_RES_MS;
         dr_s_r <= dr_m_r;
         sr_m_r <= I_SS_RES_MS;
         sr_s_r <= sr_m_r;
      end
   end

   // Bus traffic is dropped while the memory and pins load.
   assign busy = (state_r == ST_NVM) || (state_r == ST_PINS);
   assign take = (I_AVS.read || I_AVS.write) && !O_AVS_WAITREQUEST;
   assign restore = take && I_AVS.write && !busy && (I_AVS.address == ADDR_CTRL)
      && I_AVS.byteenable[0] && I_AVS.writedata[CTRL_RESTORE];
   // A short delay is lifted to the floor, a longer one kept whole.
   assign dly_eff = (dly_cfg_r < 8'(MIN_DELAY_MS)) ? 8'(MIN_DELAY_MS) : dly_cfg_r;
   // Free-running ticks may already be partly gone, so one more is counted.
   assign goal = precise_r ? {1'b0, dly_eff} : 9'({1'b0, dly_eff} + 9'h001);
   assign ss_ms = (st_s_r.ramp_strap == LVL_CUSTOM) ? sr_s_r : RAMP_TABLE[st_s_r.ramp_strap];

   // Answer every request one cycle after it appears.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         O_AVS_WAITREQUEST <= 1'b1;
      else if ((I_AVS.read || I_AVS.write) && O_AVS_WAITREQUEST)
         O_AVS_WAITREQUEST <= 1'b0;
      else
         O_AVS_WAITREQUEST <= 1'b1;
   end

   // Read data is prepared in the wait cycle; unmapped and busy reads give zero.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         O_AVS_READDATA <= 32'h0000_0000;
      else if (I_AVS.read && O_AVS_WAITREQUEST && !busy)
      begin
         case (I_AVS.address)
            ADDR_CTRL: O_AVS_READDATA <= 32'({cmd_en_r, precise_r, 1'b0});
            ADDR_DELAY: O_AVS_READDATA <= 32'(cmd_dly_r);
            ADDR_STATUS: O_AVS_READDATA <= 32'({O_TRIM_MODE, O_POWER_ON, O_RAMPING,
               O_READY, state_r});
            ADDR_CONFIG: O_AVS_READDATA <= 32'({ramp_ms_r, dly_eff});
            default: O_AVS_READDATA <= 32'h0000_0000;
         endcase
      end
      else
         O_AVS_READDATA <= 32'h0000_0000;
   end

   // Control and command-delay registers accept writes only once ready.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         precise_r <= 1'b0;
         cmd_en_r <= 1'b0;
         cmd_dly_r <= DELAY_RST;
      end
      else if (take && I_AVS.write && !busy && I_AVS.byteenable[0])
      begin
         if (I_AVS.address == ADDR_CTRL)
         begin
            precise_r <= I_AVS.writedata[CTRL_PRECISE];
            cmd_en_r <= I_AVS.writedata[CTRL_CMD_DLY];
         end
         if (I_AVS.address == ADDR_DELAY)
            cmd_dly_r <= I_AVS.writedata[7:0];
      end
   end

   // Main sequence: memory check, pin load, ready, delay, ramp, on.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         state_r <= ST_NVM;
      else if (restore)
         state_r <= ST_NVM;
      else
      begin
         case (state_r)
            ST_NVM: if (tmr_r == 20'(NVM_CYC - 1)) state_r <= ST_PINS;
            ST_PINS: state_r <= ST_READY;
            // Enable starts the sequence only from ready, so a tied-high enable waits.
            ST_READY: if (en_s_r) state_r <= ST_DELAY;
            ST_DELAY:
            begin
               if (!en_s_r)
                  state_r <= ST_READY;
               else if (dms_r >= goal)
                  state_r <= ST_RAMP;
            end
            ST_RAMP:
            begin
               if (!en_s_r)
                  state_r <= ST_READY;
               else if (O_VREF == VREF_FULL)
                  state_r <= ST_ON;
            end
            ST_ON: if (!en_s_r) state_r <= ST_READY;
            default: state_r <= ST_NVM;
         endcase
      end
   end

   // Memory check timer runs only in its own state.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         tmr_r <= 20'h00000;
      else if (state_r == ST_NVM && !restore)
         tmr_r <= 20'(tmr_r + 20'h00001);
      else
         tmr_r <= 20'h00000;
   end

   // Millisecond prescaler; in precise mode it restarts at enable.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         pre_r <= 17'h00000;
         tick_r <= 1'b0;
      end
      else if ((state_r == ST_READY && en_s_r && precise_r) || pre_r == 17'(MS_CYC - 1))
      begin
         pre_r <= 17'h00000;
         tick_r <= (pre_r == 17'(MS_CYC - 1));
      end
      else
      begin
         pre_r <= 17'(pre_r + 17'h00001);
         tick_r <= 1'b0;
      end
   end

   // Delay milliseconds, counted from the enable edge.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         dms_r <= 9'h000;
      else if (state_r != ST_DELAY)
         dms_r <= 9'h000;
      else if (tick_r && dms_r != 9'h1ff)
         dms_r <= 9'(dms_r + 9'h001);
   end

   // Settings are loaded once per start-up or restore; after that only the delay changes, taking the command delay when it is enabled.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         dly_cfg_r <= DELAY_RST;
         ramp_ms_r <= 8'h00;
         ramp_div_r <= 16'h0000;
         O_TRIM_MODE <= MODE_STD;
         O_VOUT_SEL <= 4'h0;
         O_SERIES_R <= 10'h000;
      end
      else if (state_r == ST_PINS)
      begin
         if (I_NVM_HAS_DLY)
            dly_cfg_r <= I_NVM_DLY_MS;
         else if (st_s_r.delay_fine_strap == LVL_CUSTOM)
            dly_cfg_r <= dr_s_r;
         else
            dly_cfg_r <= DLY_TABLE[idx9(st_s_r.delay_coarse_strap,
               st_s_r.delay_fine_strap)];
         ramp_ms_r <= ss_ms;
         ramp_div_r <= 16'((32'(ss_ms) * MS_CYC) / VREF_STEPS);
         if (st_s_r.vout_fine_strap == LVL_CUSTOM)
         begin
            // Trim modes steer the output setting from the coarse strap only.
            O_TRIM_MODE <= st_s_r.trim_second ? MODE_SECOND : MODE_FIRST;
            O_SERIES_R <= st_s_r.trim_second ? SERIES_SECOND : SERIES_FIRST;
            O_VOUT_SEL <= {2'b00, st_s_r.vout_coarse_strap};
         end
         else
         begin
            O_TRIM_MODE <= MODE_STD;
            O_SERIES_R <= 10'h000;
            O_VOUT_SEL <= idx9(st_s_r.vout_coarse_strap, st_s_r.vout_fine_strap);
         end
      end
      else if (cmd_en_r && !busy)
         dly_cfg_r <= cmd_dly_r;
   end

   // Reference ramp: steps up while ramping and clears to zero on disable or restore; a zero divider jumps to full scale.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         O_VREF <= 10'h000;
         stp_r <= 16'h0000;
      end
      else if (state_r == ST_RAMP && en_s_r && !restore)
      begin
         if (ramp_div_r == 16'h0000)
            O_VREF <= VREF_FULL;
         else if (stp_r >= 16'(ramp_div_r - 16'h0001))
         begin
            stp_r <= 16'h0000;
            if (O_VREF != VREF_FULL)
               O_VREF <= 10'(O_VREF + 10'h001);
         end
         else
            stp_r <= 16'(stp_r + 16'h0001);
      end
      else if (state_r != ST_ON || !en_s_r || restore)
      begin
         O_VREF <= 10'h000;
         stp_r <= 16'h0000;
      end
   end

   // Ready looks one state ahead so it stands with the ready state; the others lag one cycle.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
      begin
         O_READY <= 1'b0;
         O_RAMPING <= 1'b0;
         O_POWER_ON <= 1'b0;
      end
      else
      begin
         O_READY <= (state_r != ST_NVM) && !restore;
         O_RAMPING <= (state_r == ST_RAMP) && en_s_r && !restore;
         O_POWER_ON <= (state_r == ST_ON) && en_s_r && !restore;
      end
   end

   // Checks.
   logic [24:0] dcyc_r; // Cycles spent in the delay state.
   always_ff @(posedge I_CLK or negedge I_RSTN)
   begin
      if (!I_RSTN)
         dcyc_r <= 25'h0000000;
      else if (state_r == ST_DELAY)
         dcyc_r <= 25'(dcyc_r + 25'h0000001);
      else
         dcyc_r <= 25'h0000000;
   end

   sequence s_delay_end;
      state_r == ST_DELAY ##1 state_r == ST_RAMP;
   endsequence

   property p_nvm_time;
      @(posedge I_CLK) disable iff (!I_RSTN)
      state_r == ST_PINS |-> $past(state_r) == ST_NVM && $past(tmr_r) == 20'(NVM_CYC - 1);
   endproperty
   a_nvm_time: assert property (p_nvm_time) else $error("memory check length wrong");

   property p_pins_load;
      @(posedge I_CLK) disable iff (!I_RSTN)
      state_r == ST_PINS && !restore |=> state_r == ST_READY && ramp_ms_r == $past(ss_ms);
   endproperty
   a_pins_load: assert property (p_pins_load) else $error("pins not loaded");

   property p_busy_ignore;
      @(posedge I_CLK) disable iff (!I_RSTN)
      busy && take |=> $stable(cmd_dly_r) && $stable(precise_r) && O_AVS_READDATA == 32'h0;
   endproperty
   a_busy_ignore: assert property (p_busy_ignore) else $error("bus acted on while busy");

   property p_restore;
      @(posedge I_CLK) disable iff (!I_RSTN)
      restore |=> state_r == ST_NVM ##1 !O_READY;
   endproperty
   a_restore: assert property (p_restore) else $error("restore did not recheck");

   property p_delay_entry;
      @(posedge I_CLK) disable iff (!I_RSTN)
      $rose(state_r == ST_DELAY) |-> $past(state_r) == ST_READY && $past(O_READY);
   endproperty
   a_delay_entry: assert property (p_delay_entry) else $error("start before ready");

   property p_min_delay;
      @(posedge I_CLK) disable iff (!I_RSTN)
      s_delay_end |-> $past(dcyc_r) >= 25'(MIN_DELAY_MS * MS_CYC - 1);
   endproperty
   a_min_delay: assert property (p_min_delay) else $error("delay under floor");

   property p_full_delay;
      @(posedge I_CLK) disable iff (!I_RSTN)
      s_delay_end |-> $past(dms_r) >= {1'b0, $past(dly_eff)};
   endproperty
   a_full_delay: assert property (p_full_delay) else $error("configured delay cut");

   property p_abort;
      @(posedge I_CLK) disable iff (!I_RSTN)
      state_r == ST_DELAY && !en_s_r && !restore |=> state_r == ST_READY ##1 !O_RAMPING;
   endproperty
   a_abort: assert property (p_abort) else $error("abort failed");

   property p_monotonic;
      @(posedge I_CLK) disable iff (!I_RSTN)
      $past(state_r) == ST_RAMP && (state_r == ST_RAMP || state_r == ST_ON) && en_s_r
      |-> O_VREF >= $past(O_VREF);
   endproperty
   a_monotonic: assert property (p_monotonic) else $error("reference went down");

   property p_zero_ramp;
      @(posedge I_CLK) disable iff (!I_RSTN)
      state_r == ST_RAMP && en_s_r && !restore && ramp_div_r == 16'h0000 |=> O_VREF == VREF_FULL;
   endproperty
   a_zero_ramp: assert property (p_zero_ramp) else $error("zero ramp not immediate");
endmodule // startup_softstart_sequencer
`default_nettype wire

// ==== startup_host_model.sv ====
// Host model that drives the enable pin and masters the register bus.
`timescale 1ns/1ps
`default_nettype none
module startup_host_model
(
   // Clock and bus answer.
   input wire logic i_clk,
   input wire logic i_waitreq,
   input wire logic [31:0] i_rdata,
   // Bus request and enable pin.
   output var startup_seq_pkg::avs_req_t o_req,
   output var logic o_enable
);
   import startup_seq_pkg::*;
   // Enable starts tied high, as on a board that straps it to the supply.
   initial
   begin
      o_req = '0;
      o_enable = 1'b1;
   end
   // One transfer; the request stands until waitrequest is sampled low.
   task automatic xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge i_clk);
      o_req <= '{address: a, read: !wr, write: wr, writedata: d, byteenable: 4'hf};
      do
         @(posedge i_clk);
      while (i_waitreq !== 1'b0);
      q = i_rdata;
      o_req <= '0;
   endtask
   // The model runs on the bus clock, so enable moves just after a rising edge.
   task automatic set_en(input logic v);
      @(posedge i_clk);
      o_enable <= v;
   endtask
endmodule // startup_host_model
`default_nettype wire

// ==== startup_softstart_sequencer_tb.sv ====
// Self-checking bench for the start-up and soft-start sequencer.
`timescale 1ns/1ps
`default_nettype none
module startup_softstart_sequencer_tb;
   import startup_seq_pkg::*;
   // Short millisecond and memory-check counts keep the run brief.
   localparam int MS = 1024;
   localparam int NVM = 300;
   logic I_CLK;
   logic I_RSTN;
   strap_t straps;
   strap_t s;
   logic [7:0] dly_res;
   logic [7:0] ss_res;
   logic nvm_has; // Memory holds a stored delay.
   logic [7:0] nvm_dly; // Stored delay in ms.
   avs_req_t avs;
   logic en, wreq, ready, ramping, pwr_on, trim, seen;
   logic [31:0] rdata, q;
   logic [9:0] vref, series;
   logic [1:0] tmode;
   logic [3:0] vsel;
   int miscompares, tests_run, n, e;
   int cyc = 0;
   startup_softstart_sequencer #(.MS_CYC(MS), .NVM_CYC(NVM)) dut_u (
      .I_CLK(I_CLK), .I_RSTN(I_RSTN), .I_ENABLE(en), .I_STRAPS(straps),
      .I_DLY_RES_MS(dly_res), .I_SS_RES_MS(ss_res), .I_NVM_HAS_DLY(nvm_has),
      .I_NVM_DLY_MS(nvm_dly), .I_AVS(avs), .O_AVS_READDATA(rdata),
      .O_AVS_WAITREQUEST(wreq), .O_READY(ready), .O_RAMPING(ramping),
      .O_POWER_ON(pwr_on), .O_VREF(vref), .O_TRIM_MODE(tmode), .O_VOUT_SEL(vsel),
      .O_SERIES_R(series));
   startup_host_model host_u (.i_clk(I_CLK), .i_waitreq(wreq), .i_rdata(rdata),
      .o_req(avs), .o_enable(en));
   // Free-running 100 MHz clock.
   initial
   begin
      I_CLK = 1'b0;
      forever #5 I_CLK = ~I_CLK;
   end
   // Counts one comparison and reports a mismatch at once.
   task automatic check(input logic ok, input string what);
      tests_run++;
      if (ok !== 1'b1)
      begin
         miscompares++;
         $display("ERROR at %0t: %s", $time, what);
      end
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // A hung wait is cut short here; the ceiling is about twice the expected run.
   always @(posedge I_CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 60000)
      begin
         miscompares++;
         summarize();
      end
   end
   // Delay in ms for a coarse and fine strap level.
   function automatic int exp_dly(input int c, input int f);
      int b;
      b = (f == 0) ? 5 : (f == 1) ? 10 : 20;
      return (c == 0) ? f : (c == 1) ? b : b * 10;
   endfunction
   // Waits for the end of the memory check, which must take its full length.
   task automatic wait_ready();
      n = 0;
      while (ready !== 1'b1 && n < NVM + 20)
      begin
         @(posedge I_CLK);
         n++;
      end
      check(ready === 1'b1 && n >= NVM - 5, "ready timing");
   endtask
   // Restore repeats the memory check and reloads the straps.
   task automatic restore(input logic [31:0] ctrl);
      host_u.xfer(1'b1, ADDR_CTRL, ctrl | 32'h1, q);
      repeat (2) @(posedge I_CLK);
      check(ready === 1'b0, "no check after restore");
      wait_ready();
   endtask
   // Enable, delay, ramp and disable; lim is the latest allowed ramp start.
   task automatic run_seq(input int dly_ms, input int lim, input int ramp_ms);
      logic [9:0] last;
      logic mono;
      host_u.set_en(1'b1);
      n = 0;
      while (ramping !== 1'b1 && n < lim + 20)
      begin
         @(posedge I_CLK);
         n++;
      end
      check(n >= dly_ms * MS && n <= lim, "delay length");
      n = 0;
      last = 10'h000;
      mono = 1'b1;
      while (pwr_on !== 1'b1 && n < ramp_ms * MS + 50)
      begin
         if (vref < last)
            mono = 1'b0;
         last = vref;
         @(posedge I_CLK);
         n++;
      end
      check(mono === 1'b1, "reference stepped back");
      check(vref === VREF_FULL && n <= ramp_ms * MS + 8 && n + 16 >= ramp_ms * MS,
         "ramp time");
      host_u.set_en(1'b0);
      repeat (6) @(posedge I_CLK);
      check(vref === 10'h000 && pwr_on === 1'b0 && ready === 1'b1, "disable");
      $display("Test sequence %0d ms done", dly_ms);
   endtask
   // Main sequence.
   initial
   begin
      I_RSTN = 1'b0;
      straps = '0;
      dly_res = 8'h07;
      ss_res = 8'h03;
      nvm_has = 1'b0;
      nvm_dly = 8'h00;
      miscompares = 0;
      tests_run = 0;
      void'($urandom(32'h1c176884));
      repeat (16) @(posedge I_CLK);
      I_RSTN <= 1'b1;
      // Bus traffic in the memory check is answered but has no effect.
      host_u.xfer(1'b1, ADDR_DELAY, 32'h32, q);
      host_u.xfer(1'b0, ADDR_STATUS, 32'h0, q);
      check(q === 32'h0 && ready === 1'b0, "init read");
      // Enable has been high since power-up.
      n = 6;
      while (ramping !== 1'b1 && n < NVM + 3 * MS)
      begin
         @(posedge I_CLK);
         n++;
      end
      check(n >= NVM + 2 * MS, "early ramp");
      repeat (4) @(posedge I_CLK);
      check(vref === VREF_FULL, "zero ramp");
      host_u.set_en(1'b0);
      host_u.xfer(1'b0, ADDR_DELAY, 32'h0, q);
      check(q[7:0] === DELAY_RST, "write kept in init");
      host_u.xfer(1'b0, 4'h6, 32'h0, q);
      check(q === 32'h0, "unmapped read");
      $display("Test power-up done");
      // All nine delay straps, with random ramp and output straps.
      for (int i = 0; i < 9; i++)
      begin
         s.delay_coarse_strap = 2'(i / 3);
         s.delay_fine_strap = 2'(i % 3);
         s.ramp_strap = 2'($urandom_range(2));
         s.vout_coarse_strap = 2'($urandom_range(2));
         s.vout_fine_strap = 2'($urandom_range(3));
         s.trim_second = 1'($urandom_range(1));
         straps <= s;
         restore(32'h0);
         host_u.xfer(1'b0, ADDR_CONFIG, 32'h0, q);
         e = exp_dly(i / 3, i % 3);
         check(q[7:0] === 8'((e < 2) ? 2 : e), "delay decode");
         check(q[15:8] === 8'(s.ramp_strap * 5), "ramp decode");
         trim = (s.vout_fine_strap == 2'h3);
         check(tmode === (trim ? (s.trim_second ? 2'h2 : 2'h1) : 2'h0), "mode");
         check(series === (trim ? (s.trim_second ? 10'h362 : 10'h3e8) : 10'h000),
            "series");
         check(vsel === (trim ? 4'(s.vout_coarse_strap)
            : 4'(s.vout_coarse_strap * 3 + s.vout_fine_strap)), "vout");
      end
      $display("Test strap decode done");
      // Zero delay is stretched to 2 ms; normal timing may run 1 ms long.
      straps <= '{ramp_strap: 2'h1, default: '0};
      restore(32'h0);
      run_seq(2, 3 * MS + 8, 5);
      // Precise timing waits a 5 ms delay exactly.
      straps <= '{delay_coarse_strap: 2'h1, default: '0};
      restore(32'h2);
      run_seq(5, 5 * MS + 8, 0);
      // A 1 ms command delay is also raised to 2 ms.
      host_u.xfer(1'b1, ADDR_DELAY, 32'h1, q);
      host_u.xfer(1'b1, ADDR_CTRL, 32'h6, q);
      run_seq(2, 2 * MS + 8, 0);
      // A custom delay resistor is measured only at restore.
      straps <= '{delay_fine_strap: 2'h3, default: '0};
      restore(32'h0);
      dly_res <= 8'h28;
      repeat (10) @(posedge I_CLK);
      host_u.xfer(1'b0, ADDR_CONFIG, 32'h0, q);
      check(q[7:0] === 8'h07, "custom delay moved");
      restore(32'h0);
      host_u.xfer(1'b0, ADDR_CONFIG, 32'h0, q);
      check(q[7:0] === 8'h28, "custom delay reload");
      // A stored delay beats the straps, and a custom ramp resistor sets the ramp.
      nvm_has <= 1'b1;
      nvm_dly <= 8'(3 + $urandom_range(40));
      ss_res <= 8'($urandom_range(20));
      straps <= '{ramp_strap: 2'h3, default: '0};
      restore(32'h0);
      host_u.xfer(1'b0, ADDR_CONFIG, 32'h0, q);
      check(q[7:0] === nvm_dly, "stored delay");
      check(q[15:8] === ss_res, "custom ramp");
      nvm_has <= 1'b0;
      $display("Test custom resistor done");
      // Dropping enable in the delay abandons the start.
      straps <= '{delay_coarse_strap: 2'h1, default: '0};
      restore(32'h0);
      host_u.set_en(1'b1);
      repeat (1000) @(posedge I_CLK);
      host_u.set_en(1'b0);
      seen = 1'b0;
      repeat (6 * MS)
      begin
         @(posedge I_CLK);
         if (ramping !== 1'b0)
            seen = 1'b1;
      end
      check(seen === 1'b0 && vref === 10'h000 && ready === 1'b1, "abort");
      $display("Test abort done");
      summarize();
   end
endmodule // startup_softstart_sequencer_tb
`default_nettype wire
